// ---- bench/dpt_monitor.sv ----
// Port-level assertions for the dual pulse timer
`timescale 1ns/1ps
module dpt_monitor (
  input wire logic        pclk,     // Clock
  input wire logic        presetn,  // Reset, active low
  input wire logic        psel,     // APB select
  input wire logic        penable,  // APB enable
  input wire logic        pwrite,   // APB write
  input wire logic [11:0] paddr,    // APB address
  input wire logic [31:0] pwdata,   // APB write data
  input wire logic [31:0] prdata,   // APB read data
  input wire logic        pready,   // APB ready
  input wire logic        pslverr,  // APB error
  input wire logic        pwm_out0, // Channel 0 pin
  input wire logic        pwm_out1  // Channel 1 pin
);
  logic [15:0] ctl_q;
  logic [7:0]  psc_q;
  logic [2:0]  wcnt_q;
  wire         wr_c = psel & penable & pready & pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Pins are judged only once seven quiet cycles follow the last write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q  <= 16'h0000;
      psc_q  <= 8'h00;
      wcnt_q <= 3'h0;
    end else begin
      if (wr_c && paddr == 12'h008) ctl_q <= pwdata[15:0] & 16'h0d1d;
      if (wr_c && paddr == 12'h000) psc_q <= pwdata[7:0];
      wcnt_q <= wr_c ? 3'h0 : wcnt_q + {2'h0, wcnt_q != 3'h7};
    end
  end
  a_ready_wait:
    assert property (psel && penable && !pready |=> pready)
    else $error("pready missing after access phase");
  a_ready_pulse:
    assert property (pready |=> !pready)
    else $error("pready held over one cycle");
  a_ready_cause:
    assert property (pready |-> $past(psel && penable))
    else $error("pready without access phase");
  a_idle_rdata:
    assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data nonzero outside ready");
  a_err_map:
    assert property (pslverr |-> pready && paddr > 12'h020)
    else $error("error flag on mapped address");
  a_stop_ch0:
    assert property (wcnt_q == 3'h7 && !ctl_q[0] |-> pwm_out0 == ctl_q[2])
    else $error("channel 0 pin wrong while stopped");
  a_stop_ch1:
    assert property (wcnt_q == 3'h7 && !ctl_q[8] && !ctl_q[4]
      |-> pwm_out1 == ctl_q[10])
    else $error("channel 1 pin wrong while stopped");
  a_dead_pair:
    assert property (wcnt_q == 3'h7 && ctl_q[4] |-> pwm_out1 != pwm_out0)
    else $error("pins not complementary in dead zone mode");
  a_psc_freeze:
    assert property (wcnt_q == 3'h7 && psc_q == 8'h00
      |=> $stable({pwm_out0, pwm_out1}))
    else $error("pin moved with prescaler stopped");
endmodule

bind dpt_core dpt_monitor u_mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pwm_out0(pwm_out0), .pwm_out1(pwm_out1));

// ---- bench/tb.sv ----
// Self-checking bench for the dual pulse timer
`timescale 1ns/1ps
module tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rdv;
  logic        pready, pslverr, pwm_out0, pwm_out1, erv;
  int          err_count = 0;
  int          checks_done = 0;
  int          cyc = 0;

  always #2 pclk = ~pclk;

  dpt_core dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwm_out0(pwm_out0), .pwm_out1(pwm_out1));

  task automatic print_verdict();
    if (err_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Entered just after a rising edge; leaves one idle edge behind
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the cycle watchdog ends a wait for ready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Mode is set before the values, since its rising edge clears them
  task automatic wave(input int c, input logic [7:0] psc,
                      input logic [2:0] dv, input logic [15:0] rl, cm,
                      input logic inv, input int per, hi);
    int   n1, nr;
    logic p, q;
    n1 = 0;
    nr = 0;
    apb(1, 12'h008, 32'h0);
    apb(1, 12'h008, 32'h8 << 8 * c);
    apb(1, 12'h000, {24'h0, psc});
    apb(1, 12'h004, {29'h0, dv} << 4 * c);
    apb(1, 12'h00c + 12'(12 * c), {16'h0, rl});
    apb(1, 12'h010 + 12'(12 * c), {16'h0, cm});
    apb(1, 12'h008, {28'h1, inv, 2'h1} << 8 * c);
    repeat (2 * per) @(posedge pclk);
    q = (c ? pwm_out1 : pwm_out0) ^ inv;
    repeat (10 * per) begin
      @(posedge pclk);
      p = (c ? pwm_out1 : pwm_out0) ^ inv;
      n1 += int'(p === 1'b1);
      nr += int'(p === 1'b1 && q === 1'b0);
      q = p;
    end
    chk("high_time", n1, 10 * hi);
    chk("rise_count", nr, hi == per ? 0 : 10);
    apb(0, 12'h014 + 12'(12 * c), 32'h0);
    chk("count_range", {31'h0, rdv <= {16'h0, rl}}, 32'h1);
  endtask

  initial begin
    int n;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 8; a <= 32; a += 4) begin
      apb(0, 12'(a), 32'h0);
      chk("reset_value", rdv, 32'h0);
    end
    apb(1, 12'h00c, 32'hffff_1234);
    apb(0, 12'h00c, 32'h0);
    chk("reload_field", rdv, 32'h0000_1234);
    for (int a = 12; a <= 32; a += 4) apb(1, 12'(a), 32'h0000_0042);
    apb(1, 12'h008, 32'h0000_0808);
    for (int a = 12; a <= 32; a += 4) begin
      apb(0, 12'(a), 32'h0);
      chk("mode_clear", rdv, 32'h0);
    end
    apb(1, 12'h008, 32'hffff_ffff);
    apb(0, 12'h008, 32'h0);
    chk("control_mask", rdv, 32'h0000_0d1d);
    apb(0, 12'h024, 32'h0);
    chk("unmapped_err", {31'h0, erv}, 32'h1);
    chk("unmapped_data", rdv, 32'h0);
    wave(0, 8'h01, 3'h4, 16'h0003, 16'h0001, 1'b0, 8, 4);
    apb(1, 12'h008, 32'h0000_0019);
    n = 0;
    repeat (4) @(posedge pclk);
    repeat (40) begin
      @(posedge pclk);
      n += int'(pwm_out1 !== ~pwm_out0);
    end
    chk("dead_zone", n, 0);
    wave(0, 8'h01, 3'h0, 16'h0002, 16'h0000, 1'b1, 12, 4);
    wave(1, 8'h01, 3'h1, 16'h0001, 16'h0000, 1'b0, 16, 8);
    wave(1, 8'h02, 3'h2, 16'h0001, 16'h0000, 1'b1, 48, 24);
    wave(1, 8'h01, 3'h3, 16'h0002, 16'h0005, 1'b0, 96, 96);
    apb(1, 12'h008, 32'h0);
    apb(1, 12'h004, 32'h0000_0004);
    apb(1, 12'h00c, 32'h0000_0003);
    apb(1, 12'h010, 32'h0000_0003);
    apb(1, 12'h008, 32'h0000_0001);
    repeat (40) @(posedge pclk);
    apb(0, 12'h014, 32'h0);
    chk("oneshot_count", rdv, 32'h0);
    chk("oneshot_pin", {31'h0, pwm_out0}, 32'h0);
    print_verdict();
  end
endmodule

// ---- src/dpt_core.sv ----
// Two-channel pulse width timer with APB register access
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
module dpt_core (
  input  wire logic        pclk,     // 250 MHz bus and timer clock
  input  wire logic        presetn,  // Async reset, active low
  input  wire logic        psel,     // APB select
  input  wire logic        penable,  // APB access phase
  input  wire logic        pwrite,   // APB write
  input  wire logic [11:0] paddr,    // APB byte address
  input  wire logic [31:0] pwdata,   // APB write data
  output logic      [31:0] prdata,   // APB read data
  output logic             pready,   // APB ready
  output logic             pslverr,  // APB error, unmapped address
  output logic             pwm_out0, // Channel 0 pulse pin
  output logic             pwm_out1  // Channel 1 pulse pin
);

  dpt_pkg::dpt_state_t s_q;
  dpt_pkg::dpt_state_t s_d;

  // Channel-indexed views of control fields
  logic [1:0] run_bit;
  logic [1:0] inv_bit;
  logic [1:0] mode_bit;
  assign run_bit  = {s_q.control[dpt_pkg::RUN_BIT1],
                     s_q.control[dpt_pkg::RUN_BIT0]};
  assign inv_bit  = {s_q.control[dpt_pkg::INV_BIT1],
                     s_q.control[dpt_pkg::INV_BIT0]};
  assign mode_bit = {s_q.control[dpt_pkg::MODE_BIT1],
                     s_q.control[dpt_pkg::MODE_BIT0]};

  always_comb begin
    logic        psc_tick;
    logic [1:0]  ch_tick;
    logic [3:0]  div_last;
    logic [1:0]  raw;
    logic        ack;
    logic        mapped;
    logic [15:0] new_ctl;
    logic [31:0] rd;
    psc_tick = 1'b0;
    ch_tick  = 2'b00;
    div_last = 4'h0;
    raw      = 2'b00;
    ack      = 1'b0;
    mapped   = 1'b0;
    new_ctl  = s_q.control;
    rd       = dpt_pkg::RST_RDATA;
    s_d      = s_q;

    if (s_q.prescale != dpt_pkg::RST_PRESCALE) begin
      if (s_q.psc_cnt >= s_q.prescale) begin
        s_d.psc_cnt = dpt_pkg::RST_PRESCALE;
        psc_tick    = 1'b1;
      end else begin
        s_d.psc_cnt = s_q.psc_cnt + 8'h01;
      end
    end

    for (int c = 0; c < 2; c++) begin
      unique case (s_q.div_sel[c])
        3'h0:    div_last = 4'h1;
        3'h1:    div_last = 4'h3;
        3'h2:    div_last = 4'h7;
        3'h3:    div_last = 4'hf;
        default: div_last = 4'h0;  // Code 4 and unused codes pass through
      endcase
      if (psc_tick) begin
        if (s_q.div_cnt[c] >= div_last) begin
          s_d.div_cnt[c] = 4'h0;
          ch_tick[c]     = 1'b1;
        end else begin
          s_d.div_cnt[c] = s_q.div_cnt[c] + 4'h1;
        end
      end

      s_d.run_seen[c] = run_bit[c];
      if (!run_bit[c]) begin
        s_d.active[c] = 1'b0;
      end else if (!s_q.run_seen[c]) begin
        s_d.active[c]      = 1'b1;
        s_d.count[c]       = s_q.reload[c];
        s_d.act_reload[c]  = s_q.reload[c];
        s_d.act_compare[c] = s_q.compare[c];
      end else if (s_q.active[c] && ch_tick[c]) begin
        if (s_q.count[c] != dpt_pkg::RST_VALUE16) begin
          s_d.count[c] = s_q.count[c] - 16'h0001;
        end else if (mode_bit[c]) begin
          // new values take hold at period start
          s_d.count[c]       = s_q.reload[c];
          s_d.act_reload[c]  = s_q.reload[c];
          s_d.act_compare[c] = s_q.compare[c];
        end else begin
          s_d.active[c] = 1'b0;
        end
      end

      raw[c] = s_q.active[c] && (s_q.count[c] <= s_q.act_compare[c]);
    end

    s_d.pwm[0] = raw[0] ^ inv_bit[0];
    // dead zone makes channel 1 the complement of channel 0
    if (s_q.control[dpt_pkg::DEADZONE_BIT]) begin
      s_d.pwm[1] = ~(raw[0] ^ inv_bit[0]);
    end else begin
      s_d.pwm[1] = raw[1] ^ inv_bit[1];
    end

    // Answer one cycle into the access phase; commit on the ready edge
    ack           = psel && penable && s_q.pready;
    s_d.pready    = psel && penable && !s_q.pready;
    unique case (paddr)
      dpt_pkg::OFS_PRESCALE: begin
        mapped = 1'b1;
        rd     = {24'h00_0000, s_q.prescale};
      end
      dpt_pkg::OFS_DIVIDER: begin
        mapped = 1'b1;
        rd     = {25'h000_0000, s_q.div_sel[1], 1'b0, s_q.div_sel[0]};
      end
      dpt_pkg::OFS_CONTROL: begin
        mapped = 1'b1;
        rd     = {16'h0000, s_q.control};
      end
      dpt_pkg::OFS_RELOAD0: begin
        mapped = 1'b1;
        rd     = {16'h0000, s_q.reload[0]};
      end
      dpt_pkg::OFS_COMPARE0: begin
        mapped = 1'b1;
        rd     = {16'h0000, s_q.compare[0]};
      end
      dpt_pkg::OFS_COUNT0: begin
        mapped = 1'b1;
        rd     = {16'h0000, s_q.count[0]};
      end
      dpt_pkg::OFS_RELOAD1: begin
        mapped = 1'b1;
        rd     = {16'h0000, s_q.reload[1]};
      end
      dpt_pkg::OFS_COMPARE1: begin
        mapped = 1'b1;
        rd     = {16'h0000, s_q.compare[1]};
      end
      dpt_pkg::OFS_COUNT1: begin
        mapped = 1'b1;
        rd     = {16'h0000, s_q.count[1]};
      end
      default: begin
        mapped = 1'b0;
        rd     = dpt_pkg::RST_RDATA;
      end
    endcase
    if (s_d.pready) begin
      s_d.prdata  = pwrite ? dpt_pkg::RST_RDATA : rd;
      s_d.pslverr = !mapped;
    end else begin
      s_d.prdata  = dpt_pkg::RST_RDATA;
      s_d.pslverr = 1'b0;
    end

    if (ack && pwrite && mapped) begin
      unique case (paddr)
        dpt_pkg::OFS_PRESCALE: begin
          s_d.prescale = pwdata[7:0];
          s_d.psc_cnt  = dpt_pkg::RST_PRESCALE;
        end
        dpt_pkg::OFS_DIVIDER: begin
          s_d.div_sel[0] = pwdata[dpt_pkg::DIV_LSB0 +: 3];
          s_d.div_sel[1] = pwdata[dpt_pkg::DIV_LSB1 +: 3];
        end
        dpt_pkg::OFS_CONTROL: begin
          new_ctl     = pwdata[15:0] & dpt_pkg::CONTROL_MASK;
          s_d.control = new_ctl;
          // rising mode bit clears channel 0 values
          if (new_ctl[dpt_pkg::MODE_BIT0] && !mode_bit[0]) begin
            s_d.reload[0]  = dpt_pkg::RST_VALUE16;
            s_d.compare[0] = dpt_pkg::RST_VALUE16;
          end
          // rising mode bit clears channel 1 values
          if (new_ctl[dpt_pkg::MODE_BIT1] && !mode_bit[1]) begin
            s_d.reload[1]  = dpt_pkg::RST_VALUE16;
            s_d.compare[1] = dpt_pkg::RST_VALUE16;
          end
        end
        dpt_pkg::OFS_RELOAD0:  s_d.reload[0]  = pwdata[15:0];
        dpt_pkg::OFS_COMPARE0: s_d.compare[0] = pwdata[15:0];
        dpt_pkg::OFS_RELOAD1:  s_d.reload[1]  = pwdata[15:0];
        dpt_pkg::OFS_COMPARE1: s_d.compare[1] = pwdata[15:0];
        default: begin
          // Count registers ignore writes
          s_d.control = s_q.control;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata   = s_q.prdata;
  assign pready   = s_q.pready;
  assign pslverr  = s_q.pslverr;
  assign pwm_out0 = s_q.pwm[0];
  assign pwm_out1 = s_q.pwm[1];

endmodule

// ---- src/dpt_pkg.sv ----
// Constants, register map and state type for the dual pulse timer
// Operation
// - Control bit 11 picks channel 1 one-shot (0) or auto-reload (1)
// - Rising channel 1 mode bit clears channel 1 reload and compare
// - Control bit 10 inverts the channel 1 output when dead-zone pairing is off
// - Control bit 8 runs channel 1 when set, stops it when clear
// - Control bit 4 enables dead-zone pairing; outputs become complementary
// - Control bit 3 picks channel 0 one-shot (0) or auto-reload (1)
// - Rising channel 0 mode bit clears channel 0 reload and compare
// - Control bit 2 inverts the channel 0 output
// - Control bit 0 runs channel 0 when set, stops it when clear
// - Reload register bits 15:0 hold the 16-bit counter reload point
// - Frequency is clock over prescale plus one, divider, reload plus one
// - Duty is compare plus one over reload plus one, 16-bit compare
// - Compare at or above reload keeps the output high all period
// - Otherwise low for reload minus compare, high for compare plus one
// - Compare zero gives low for reload cycles, high for one cycle
// - Reload writes apply only from the next period
// - Compare writes apply only from the next period
// - Count registers return each channel's present down counter value
// - Prescaler divides by setting plus one; zero halts both counters
// - Divider codes 0..4 divide by 2, 4, 8, 16 and 1
package dpt_pkg;

  localparam logic [11:0] OFS_PRESCALE = 12'h000;
  localparam logic [11:0] OFS_DIVIDER  = 12'h004;
  localparam logic [11:0] OFS_CONTROL  = 12'h008;
  localparam logic [11:0] OFS_RELOAD0  = 12'h00c;
  localparam logic [11:0] OFS_COMPARE0 = 12'h010;
  localparam logic [11:0] OFS_COUNT0   = 12'h014;
  localparam logic [11:0] OFS_RELOAD1  = 12'h018;
  localparam logic [11:0] OFS_COMPARE1 = 12'h01c;
  localparam logic [11:0] OFS_COUNT1   = 12'h020;

  // Control bit positions, indexed by channel
  localparam int unsigned RUN_BIT0     = 0;
  localparam int unsigned RUN_BIT1     = 8;
  localparam int unsigned INV_BIT0     = 2;
  localparam int unsigned INV_BIT1     = 10;
  localparam int unsigned MODE_BIT0    = 3;
  localparam int unsigned MODE_BIT1    = 11;
  localparam int unsigned DEADZONE_BIT = 4;
  localparam logic [15:0] CONTROL_MASK = 16'h0d1d;

  // Divider select fields: channel 0 in 2:0, channel 1 in 6:4
  localparam int unsigned DIV_LSB0  = 0;
  localparam int unsigned DIV_LSB1  = 4;
  localparam logic [2:0]  DIV_BY_ONE = 3'h4;

  localparam logic [15:0] RST_CONTROL  = 16'h0000;
  localparam logic [15:0] RST_VALUE16  = 16'h0000;
  localparam logic [7:0]  RST_PRESCALE = 8'h00;
  localparam logic [2:0]  RST_DIVIDER  = 3'h0;
  localparam logic [31:0] RST_RDATA    = 32'h0000_0000;

  typedef struct packed {
    logic [7:0]       prescale;   // Shared prescale setting
    logic [7:0]       psc_cnt;
    logic [1:0][2:0]  div_sel;
    logic [1:0][3:0]  div_cnt;
    logic [15:0]      control;
    logic [1:0][15:0] reload;     // Software copies
    logic [1:0][15:0] compare;
    logic [1:0][15:0] act_reload; // Copies in force this period
    logic [1:0][15:0] act_compare;
    logic [1:0][15:0] count;
    logic [1:0]       active;     // Counting, not finished one-shot
    logic [1:0]       run_seen;   // Run bit last cycle, for start edge
    logic [1:0]       pwm;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
  } dpt_state_t;

endpackage
